// ---- logic/sru_pkg.sv ----
// constants and types shared by the shift and rotate unit
package sru_pkg;

    // ========================================
    // operand widths
    localparam int WORD_W = 32;
    localparam int ADDR_W = 12;
    localparam int ROT_W = 5;
    localparam int SHAMT_W = 6;

    // ========================================
    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_SOURCE = 12'h004;
    localparam logic [11:0] OFF_AMOUNT = 12'h008;
    localparam logic [11:0] OFF_CMD = 12'h00C;
    localparam logic [11:0] OFF_RESULT = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;

    // ========================================
    // control register fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_W = 3;
    localparam int CTRL_RECORD_BIT = 4;
    localparam int CTRL_SO_BIT = 5;
    localparam int CTRL_MB_LSB = 8;
    localparam int CTRL_ME_LSB = 16;
    localparam int CTRL_SH_LSB = 24;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h1F1F1F37;

    // ========================================
    // command register fields
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;

    // ========================================
    // status register fields
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_BADOP_BIT = 2;
    localparam int STAT_CR0_LSB = 4;

    // ========================================
    // condition field bit order: less, greater, equal, summary overflow
    localparam int CR0_LT = 3;
    localparam int CR0_GT = 2;
    localparam int CR0_EQ = 1;
    localparam int CR0_SO = 0;

    // ========================================
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [3:0] CR0_RESET = 4'h0;

    // operation select, in control register op field order
    typedef enum logic [2:0] {
        SRU_OP_ROTMASK,
        SRU_OP_ROTATE,
        SRU_OP_SHL,
        SRU_OP_SHR,
        SRU_OP_SRA_REG,
        SRU_OP_SRA_IMM,
        SRU_OP_RSVD6,
        SRU_OP_RSVD7
    } sru_op_t;

endpackage

// ---- logic/sru_shift_rotate_unit.sv ----
// shift and rotate execution unit with apb register access
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns

module sru_shift_rotate_unit (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // result towards the register file
    output logic [31:0] destination_register,
    output logic carry_flag,
    output logic [3:0] condition_field_zero,
    output logic result_strobe
);

    // ========================================
    // state
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] source_reg;
    logic [31:0] source_next;
    logic [31:0] amount_reg;
    logic [31:0] amount_next;
    logic [31:0] result_reg;
    logic [31:0] result_next;
    logic carry_reg;
    logic carry_next;
    logic [3:0] cr0_reg;
    logic [3:0] cr0_next;
    logic valid_reg;
    logic valid_next;
    logic badop_reg;
    logic badop_next;
    logic strobe_reg;
    logic strobe_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pslverr_reg;
    logic pslverr_next;

    // ========================================
    // decoded instruction fields
    sru_pkg::sru_op_t op;
    logic [4:0] mask_begin_field;
    logic [4:0] mask_end_field;
    logic [4:0] shift_amount_field;
    logic record_bit;
    logic summary_overflow;

    assign op = sru_pkg::sru_op_t'(
        ctrl_reg[sru_pkg::CTRL_OP_LSB +: sru_pkg::CTRL_OP_W]);
    assign mask_begin_field = ctrl_reg[sru_pkg::CTRL_MB_LSB +: 5];
    assign mask_end_field = ctrl_reg[sru_pkg::CTRL_ME_LSB +: 5];
    assign shift_amount_field = ctrl_reg[sru_pkg::CTRL_SH_LSB +: 5];
    assign record_bit = ctrl_reg[sru_pkg::CTRL_RECORD_BIT];
    assign summary_overflow = ctrl_reg[sru_pkg::CTRL_SO_BIT];

    // ========================================
    // datapath
    logic [4:0] rot_n;
    logic [5:0] shamt;
    logic [63:0] rot_wide;
    logic [31:0] rotated;
    logic [31:0] mask;
    logic [31:0] lost_mask;
    logic [31:0] dp_result;
    logic dp_carry;
    logic dp_sets_carry;
    logic dp_ok;
    logic sign_bit;
    logic [4:0] eff_begin;
    logic [4:0] eff_end;
    logic [3:0] dp_cr0;

    // rotate amount from the low five bits of the amount register
    assign rot_n = amount_reg[sru_pkg::ROT_W-1:0];
    // six-bit shift amount, or the instruction field for the immediate form
    assign shamt = (op == sru_pkg::SRU_OP_SRA_IMM) ?
        {1'b0, shift_amount_field} :
        amount_reg[sru_pkg::SHAMT_W-1:0];
    assign sign_bit = source_reg[sru_pkg::WORD_W-1];
    assign rot_wide = {source_reg, source_reg} << rot_n;
    assign rotated = rot_wide[63:32];
    // plain rotate forces the full-word mask
    assign eff_begin = (op == sru_pkg::SRU_OP_ROTATE) ?
        5'h00 : mask_begin_field;
    assign eff_end = (op == sru_pkg::SRU_OP_ROTATE) ?
        5'h1F : mask_end_field;

    // mask in msb-first position numbering, position p is bit 31-p
    always_comb begin
        mask = '0;
        for (int p = 0; p < sru_pkg::WORD_W; p++) begin
            if (eff_begin <= eff_end) begin
                mask[31-p] = (5'(p) >= eff_begin) &&
                    (5'(p) <= eff_end);
            end else begin
                mask[31-p] = (5'(p) >= eff_begin) ||
                    (5'(p) <= eff_end);
            end
        end
    end

    // bits that leave the low end on a right shift
    assign lost_mask = ~(32'hFFFFFFFF << shamt[4:0]);

    always_comb begin
        dp_result = '0;
        dp_carry = 1'b0;
        dp_sets_carry = 1'b0;
        dp_ok = 1'b1;
        case (op)
            sru_pkg::SRU_OP_ROTMASK,
            sru_pkg::SRU_OP_ROTATE: begin
                dp_result = rotated & mask;
            end
            sru_pkg::SRU_OP_SHL: begin
                if (shamt[5]) begin
                    dp_result = '0;
                end else begin
                    dp_result = source_reg << shamt[4:0];
                end
            end
            sru_pkg::SRU_OP_SHR: begin
                if (shamt[5]) begin
                    dp_result = '0;
                end else begin
                    dp_result = source_reg >> shamt[4:0];
                end
            end
            sru_pkg::SRU_OP_SRA_REG,
            sru_pkg::SRU_OP_SRA_IMM: begin
                dp_sets_carry = 1'b1;
                if (shamt[5]) begin
                    dp_result = {sru_pkg::WORD_W{sign_bit}};
                    dp_carry = sign_bit;
                end else begin
                    dp_result = 32'($signed(source_reg) >>>
                        shamt[4:0]);
                    dp_carry = sign_bit &
                        (|(source_reg & lost_mask));
                end
            end
            default: begin
                dp_ok = 1'b0;
            end
        endcase
    end

    // signed compare of the result with zero
    always_comb begin
        dp_cr0 = '0;
        dp_cr0[sru_pkg::CR0_LT] = dp_result[31];
        dp_cr0[sru_pkg::CR0_GT] = !dp_result[31] &&
            (dp_result != '0);
        dp_cr0[sru_pkg::CR0_EQ] = (dp_result == '0);
        dp_cr0[sru_pkg::CR0_SO] = summary_overflow;
    end

    // ========================================
    // register access and result capture
    logic apb_setup;
    logic apb_wr;
    logic go;
    logic clear;
    logic [31:0] status_word;

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign go = apb_wr && (paddr == sru_pkg::OFF_CMD) &&
        pwdata[sru_pkg::CMD_GO_BIT];
    assign clear = apb_wr && (paddr == sru_pkg::OFF_CMD) &&
        pwdata[sru_pkg::CMD_CLEAR_BIT];

    always_comb begin
        status_word = '0;
        status_word[sru_pkg::STAT_CARRY_BIT] = carry_reg;
        status_word[sru_pkg::STAT_VALID_BIT] = valid_reg;
        status_word[sru_pkg::STAT_BADOP_BIT] = badop_reg;
        status_word[sru_pkg::STAT_CR0_LSB +: 4] = cr0_reg;
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        source_next = source_reg;
        amount_next = amount_reg;
        result_next = result_reg;
        carry_next = carry_reg;
        cr0_next = cr0_reg;
        valid_next = valid_reg;
        badop_next = badop_reg;
        strobe_next = 1'b0;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        // read data and error prepared in the setup cycle
        if (apb_setup) begin
            pslverr_next = 1'b0;
            prdata_next = '0;
            case (paddr)
                sru_pkg::OFF_CTRL: prdata_next = ctrl_reg;
                sru_pkg::OFF_SOURCE: prdata_next = source_reg;
                sru_pkg::OFF_AMOUNT: prdata_next = amount_reg;
                sru_pkg::OFF_CMD: prdata_next = '0;
                sru_pkg::OFF_RESULT: prdata_next = result_reg;
                sru_pkg::OFF_STATUS: prdata_next = status_word;
                default: pslverr_next = 1'b1;
            endcase
        end
        if (apb_wr) begin
            case (paddr)
                sru_pkg::OFF_CTRL: begin
                    ctrl_next = pwdata & sru_pkg::CTRL_WRITE_MASK;
                end
                sru_pkg::OFF_SOURCE: source_next = pwdata;
                sru_pkg::OFF_AMOUNT: amount_next = pwdata;
                default: begin
                end
            endcase
        end
        // clear first so that a simultaneous execute wins
        if (clear) begin
            valid_next = 1'b0;
            badop_next = 1'b0;
        end
        if (go) begin
            if (dp_ok) begin
                result_next = dp_result;
                valid_next = 1'b1;
                strobe_next = 1'b1;
                if (dp_sets_carry) begin
                    carry_next = dp_carry;
                end
                if (record_bit) begin
                    cr0_next = dp_cr0;
                end
            end else begin
                badop_next = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= sru_pkg::CTRL_RESET;
            source_reg <= sru_pkg::WORD_RESET;
            amount_reg <= sru_pkg::WORD_RESET;
            result_reg <= sru_pkg::WORD_RESET;
            carry_reg <= 1'b0;
            cr0_reg <= sru_pkg::CR0_RESET;
            valid_reg <= 1'b0;
            badop_reg <= 1'b0;
            strobe_reg <= 1'b0;
            prdata_reg <= sru_pkg::WORD_RESET;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            source_reg <= source_next;
            amount_reg <= amount_next;
            result_reg <= result_next;
            carry_reg <= carry_next;
            cr0_reg <= cr0_next;
            valid_reg <= valid_next;
            badop_reg <= badop_next;
            strobe_reg <= strobe_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ========================================
    // outputs
    assign pready = psel && penable;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign destination_register = result_reg;
    assign carry_flag = carry_reg;
    assign condition_field_zero = cr0_reg;
    assign result_strobe = strobe_reg;

endmodule

// ---- sim/sru_props.sv ----
// checker on the ports of the shift and rotate unit
`timescale 1ns/1ns
module sru_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // result
    input wire logic [31:0] destination_register,
    input wire logic carry_flag,
    input wire logic [3:0] condition_field_zero,
    input wire logic result_strobe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic go;
    assign acc = psel && penable;
    assign go = acc && pwrite && paddr == 12'h00C && pwdata[0];
    // ========================================
    // assertions
    a_ready_access: assert property (pready == acc)
        else $error("pready differs from access phase");
    a_strobe_cause: assert property (result_strobe |-> $past(go))
        else $error("strobe without execute");
    a_strobe_single: assert property (result_strobe |=> !result_strobe)
        else $error("strobe longer than one cycle");
    a_result_hold: assert property (
        !go |=> $stable(destination_register))
        else $error("result changed without execute");
    a_carry_hold: assert property (
        !go |=> $stable(carry_flag))
        else $error("carry changed without execute");
    a_cr_hold: assert property (
        !go |=> $stable(condition_field_zero))
        else $error("condition field changed without execute");
    a_unmapped_err: assert property (
        acc && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        acc && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_result_read: assert property (
        acc && !pwrite && paddr == 12'h010 |-> prdata == destination_register)
        else $error("result read differs from output");
    c_go: cover property (go);
    c_strobe: cover property (result_strobe);
    c_err: cover property (acc && pslverr);
endmodule
bind sru_shift_rotate_unit sru_props sru_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .destination_register(destination_register), .carry_flag(carry_flag),
    .condition_field_zero(condition_field_zero),
    .result_strobe(result_strobe)
);

// ---- sim/sru_regfile_model.sv ----
// register file model counting results handed over by the unit
`timescale 1ns/1ns
module sru_regfile_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // result from the unit
    input wire logic result_strobe,
    // writes taken
    output int wr_count
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_count <= 0;
        end else if (result_strobe) begin
            wr_count <= wr_count + 1;
        end
    end
endmodule

// ---- sim/shift_rotate_unit_bench.sv ----
// self-checking bench for the shift and rotate unit
`timescale 1ns/1ns
module shift_rotate_unit_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dst, rd, e_res;
    logic ca, stb, err, e_ca;
    logic [3:0] cr0, e_cr;
    int wr_count, n_mismatch, check_count;
    sru_shift_rotate_unit sru_shift_rotate_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .destination_register(dst),
        .carry_flag(ca), .condition_field_zero(cr0), .result_strobe(stb)
    );
    sru_regfile_model sru_regfile_model_i (
        .pclk(pclk), .presetn(presetn), .result_strobe(stb),
        .wr_count(wr_count)
    );
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // ========================================
    // apb master, waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge pclk);
        if (k == 16) begin
            n_mismatch++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] mask(input int b, input int e);
        for (int p = 0; p < 32; p++) begin
            mask[31 - p] = (b <= e) ? (p >= b && p <= e) : (p >= b || p <= e);
        end
    endfunction
    // ========================================
    // one execute with expected values
    task automatic run(input logic [31:0] c, input logic [31:0] s,
                       input logic [31:0] a);
        int n;
        int w0;
        logic [31:0] r;
        w0 = wr_count;
        n = (c[2:0] == 3'h5) ? int'(c[28:24]) : (a[5] ? 32 : int'(a[4:0]));
        r = (s << a[4:0]) | (s >> (32 - a[4:0]));
        case (c[2:0])
            3'h0: e_res = r & mask(c[12:8], c[20:16]);
            3'h1: e_res = r;
            3'h2: e_res = a[5] ? 32'h0 : s << a[4:0];
            3'h3: e_res = a[5] ? 32'h0 : s >> a[4:0];
            3'h4, 3'h5: begin
                e_res = $signed(s) >>> n;
                e_ca = s[31] && ((s << (32 - n)) != 32'h0);
            end
            default: ;
        endcase
        if (c[4] && c[2:0] < 3'h6) begin
            e_cr = {e_res[31], !e_res[31] && e_res != 0, e_res == 0, c[5]};
        end
        apb(1'b1, 12'h000, c);
        apb(1'b1, 12'h004, s);
        apb(1'b1, 12'h008, a);
        apb(1'b1, 12'h00C, 32'h1);
        @(posedge pclk);
        #1;
        chk(dst, e_res);
        chk({31'h0, ca}, {31'h0, e_ca});
        chk({28'h0, cr0}, {28'h0, e_cr});
        chk(wr_count - w0, (c[2:0] < 3'h6) ? 1 : 0);
    endtask
    task automatic t_rst;
        chk(dst, 32'h0);
        chk({26'h0, ca, cr0, stb}, 32'h0);
        apb(1'b0, 12'h014, 0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h018, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'hFFFFFFFF);
        apb(1'b0, 12'h000, 0);
        chk(rd, 32'h1F1F1F37);
        $display("test reset done");
    endtask
    task automatic t_rot;
        run(32'h001B0400, 32'h800000F1, 32'hFFFFFFE5);
        run(32'h00031C00, 32'h12345678, 32'h0000001F);
        run(32'h00101000, 32'hFFFFFFFF, 32'h00000000);
        run(32'h00031C01, 32'hF000000F, 32'h00000024);
        $display("test rotate done");
    endtask
    task automatic t_log;
        logic [31:0] am [6] = '{0, 1, 31, 32, 63, 32'hFFFFFFC1};
        for (int i = 0; i < 6; i++) begin
            run(32'h2, 32'hC0000003, am[i]);
            run(32'h3, 32'hC0000003, am[i]);
        end
        $display("test logical done");
    endtask
    task automatic t_ari;
        run(32'h4, 32'h80000010, 32'h4);
        run(32'h4, 32'h80000000, 32'h4);
        run(32'h4, 32'h7FFFFFFF, 32'h4);
        run(32'h4, 32'h80000000, 32'h20);
        run(32'h4, 32'h00001234, 32'h28);
        run(32'h1F000005, 32'h80000001, 32'h0);
        run(32'h00000005, 32'h80000001, 32'h7);
        $display("test arith done");
    endtask
    task automatic t_rec;
        run(32'h12, 32'h1, 32'h1F);
        run(32'h32, 32'h1, 32'h0);
        run(32'h12, 32'h1, 32'h20);
        run(32'h2, 32'h1, 32'h1);
        $display("test record done");
    endtask
    task automatic t_bad;
        run(32'h16, 32'h5, 32'h1);
        run(32'h7, 32'h5, 32'h1);
        apb(1'b0, 12'h014, 0);
        chk(rd[7:0], {e_cr, 1'b0, 2'h3, e_ca});
        apb(1'b1, 12'h00C, 32'h2);
        apb(1'b0, 12'h014, 0);
        chk(rd[2:1], 2'h0);
        apb(1'b0, 12'h010, 0);
        chk(rd, e_res);
        $display("test badop done");
    endtask
    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        n_mismatch = 0;
        check_count = 0;
        {e_res, e_ca, e_cr} = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_rst();
        t_rot();
        t_log();
        t_ari();
        t_rec();
        t_bad();
        complete_run();
    end
endmodule
